// ### logic/embedded_link_if.sv
// Two-wire embedded link between the upstream and downstream ports.
// Each line is resolved as a wired OR of the two drivers, pulled low when idle.
`timescale 1ns/10ps
interface embedded_link_if;
    logic up_pos_out;
    logic up_pos_oe;
    logic up_neg_out;
    logic up_neg_oe;
    logic dn_pos_out;
    logic dn_pos_oe;
    logic dn_neg_out;
    logic dn_neg_oe;
    logic embedded_line_positive;
    logic embedded_line_negative;

    assign embedded_line_positive = (up_pos_oe & up_pos_out) | (dn_pos_oe & dn_pos_out);
    assign embedded_line_negative = (up_neg_oe & up_neg_out) | (dn_neg_oe & dn_neg_out);

    modport upstream (
        output up_pos_out, up_pos_oe, up_neg_out, up_neg_oe,
        input  embedded_line_positive, embedded_line_negative
    );
    modport downstream (
        output dn_pos_out, dn_pos_oe, dn_neg_out, dn_neg_oe,
        input  embedded_line_positive, embedded_line_negative
    );
endinterface : embedded_link_if

// ### logic/link_pm_pkg.sv
// Shared constants and types for the embedded link power-management ends.
// Assumes a 125 MHz port clock on both ends.
package link_pm_pkg;
    localparam int unsigned CLK_MHZ          = 125;
    localparam int unsigned IDLE_L2_US       = 3000;
    localparam int unsigned IDLE_L2_CYCLES   = IDLE_L2_US * CLK_MHZ;
    localparam int unsigned LS_UI_NS         = 667;
    localparam int unsigned LS_UI_CYCLES     = (LS_UI_NS * CLK_MHZ) / 1000;
    localparam int unsigned PING_CYCLES      = LS_UI_CYCLES;
    localparam int unsigned EOP_CYCLES       = 2 * LS_UI_CYCLES;
    localparam int unsigned SE1_CYCLES       = 4 * LS_UI_CYCLES;
    localparam int unsigned K_MIN_US         = 1000;
    localparam int unsigned K_MIN_CYCLES     = K_MIN_US * CLK_MHZ;
    localparam int unsigned RESUME_ACK_US    = 1000;
    localparam int unsigned RESUME_ACK_CYCLES = RESUME_ACK_US * CLK_MHZ;
    localparam int unsigned PING_WAIT_CYCLES = 8 * LS_UI_CYCLES;
    localparam int unsigned BUS_RESET_CYCLES = 4 * LS_UI_CYCLES;

    typedef enum logic [1:0] {
        SPEED_LS = 2'b00,
        SPEED_FS = 2'b01,
        SPEED_HS = 2'b10
    } speed_t;

    typedef enum logic [1:0] {
        LINK_L0    = 2'b00,
        LINK_L1    = 2'b01,
        LINK_L2    = 2'b10,
        LINK_RESET = 2'b11
    } link_state_t;
endpackage : link_pm_pkg

// ### logic/native_downstream_port.sv
// Downstream (host) end of the embedded link: directed L1/L2, resume, end of resume,
// answer to remote wake and ping check.
// Assumes the controller holds its commands as levels.
`timescale 1ns/10ps
module native_downstream_port
    import link_pm_pkg::*;
#(
    parameter int unsigned RESUME_CYCLES = K_MIN_CYCLES,
    parameter int unsigned ACK_CYCLES    = RESUME_ACK_CYCLES
) (
    input  wire logic          mclk,
    input  wire logic          reset_n,
    embedded_link_if.downstream link,
    input  wire speed_t        speed,
    input  wire logic          l1_request,
    input  wire logic          l2_request,
    input  wire logic          resume_request,
    output link_state_t        link_state,
    output logic               wake_seen,
    output logic               went_default
);
    typedef enum logic [4:0] {
        ST_L0     = 5'b0_0001,
        ST_LOW    = 5'b0_0010,
        ST_RESUME = 5'b0_0100,
        ST_END    = 5'b0_1000,
        ST_WAIT   = 5'b1_0000
    } dn_state_t;

    // One width serves every counter, so it must hold the longest timed phase.
    localparam int CW = $clog2(RESUME_CYCLES + ACK_CYCLES + PING_WAIT_CYCLES + EOP_CYCLES + 2);

    initial begin
        if (RESUME_CYCLES < 1 || ACK_CYCLES < 1) begin
            $error("native_downstream_port: counts must be at least one");
        end
    end

    dn_state_t     state;
    logic [CW-1:0] count;
    logic          low_is_l2;
    logic          k_line;
    logic          ping_line;
    logic [CW-1:0] end_len;

    assign k_line    = (speed == SPEED_LS) ? link.embedded_line_positive
                                           : link.embedded_line_negative;
    assign ping_line = k_line;
    assign end_len   = (speed == SPEED_HS) ? CW'(PING_CYCLES) : CW'(EOP_CYCLES);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state        <= ST_L0;
            count        <= '0;
            low_is_l2    <= 1'b0;
            wake_seen    <= 1'b0;
            went_default <= 1'b0;
        end else begin
            went_default <= 1'b0;
            case (state)
                ST_L0: begin
                    count <= '0;
                    if (l1_request || l2_request) begin
                        state     <= ST_LOW;
                        low_is_l2 <= l2_request;
                    end
                end
                ST_LOW: begin
                    if (resume_request) begin
                        state <= ST_RESUME;
                        count <= '0;
                    end else if (k_line) begin
                        wake_seen <= 1'b1;
                        // Answer before the acknowledge window runs out.
                        if (count == CW'(ACK_CYCLES / 2)) begin
                            state <= ST_RESUME;
                            count <= '0;
                        end else begin
                            count <= count + 1'b1;
                        end
                    end
                end
                ST_RESUME: begin
                    if (count == CW'(RESUME_CYCLES - 1)) begin
                        state <= ST_END;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                ST_END: begin
                    if (count == end_len - 1'b1) begin
                        state <= (speed == SPEED_HS) ? ST_L0 : ST_WAIT;
                        count <= '0;
                        wake_seen <= 1'b0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (ping_line) begin
                        state <= ST_L0;
                    end else if (count == CW'(PING_WAIT_CYCLES - 1)) begin
                        state        <= ST_L0;
                        went_default <= 1'b1;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                default: begin
                    state <= ST_L0;
                    count <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            link.dn_pos_out <= 1'b0;
            link.dn_pos_oe  <= 1'b0;
            link.dn_neg_out <= 1'b0;
            link.dn_neg_oe  <= 1'b0;
            link_state      <= LINK_L0;
        end else begin
            // Resume K on the speed line; EOP or end-of-resume on the other.
            link.dn_pos_out <= (state == ST_RESUME && speed == SPEED_LS)
                             || (state == ST_END && speed != SPEED_LS);
            link.dn_pos_oe  <= (state == ST_RESUME && speed == SPEED_LS)
                             || (state == ST_END && speed != SPEED_LS);
            link.dn_neg_out <= (state == ST_RESUME && speed != SPEED_LS)
                             || (state == ST_END && speed == SPEED_LS);
            link.dn_neg_oe  <= (state == ST_RESUME && speed != SPEED_LS)
                             || (state == ST_END && speed == SPEED_LS);
            link_state      <= (state == ST_LOW) ? (low_is_l2 ? LINK_L2 : LINK_L1) : LINK_L0;
        end
    end
endmodule : native_downstream_port

// ### logic/native_upstream_port.sv
// Upstream (device) end of the embedded link: L1/L2 entry, resume exit, remote wake,
// soft disconnect and bus reset detection.
// Assumes the link interface resolves line levels and the controller holds its commands.
// Operation
// - Both ends support L1 via LPM.
// - L2 suspend after 3ms continuous idle.
// - Upstream enters L1 when directed.
// - Downstream enters L1/L2 only when directed.
// - FS: EOP on positive, ping negative.
// - LS: EOP on negative, ping positive.
// - HS: end-of-resume enters L0, no ping.
// - Host resume K on speed-dependent line.
// - Host ends FS/LS resume with EOP.
// - HS end-of-resume is one UI pulse.
// - Host defaults when no ping returns.
// - Remote wake K on speed-dependent line.
// - Host answers wake within acknowledge window.
// - Wake ends with end-of-resume, then ping at FS/LS.
// - Soft disconnect sends port reset announcement.
// - Bus reset from L0/L1/L2 enters reset.
`timescale 1ns/10ps
module native_upstream_port
    import link_pm_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = IDLE_L2_CYCLES,
    parameter int unsigned WAKE_CYCLES = K_MIN_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    embedded_link_if.upstream link,
    input  wire speed_t      speed,
    input  wire logic        l1_request,
    input  wire logic        l2_request,
    input  wire logic        wake_request,
    input  wire logic        soft_disconnect,
    output link_state_t      link_state,
    output logic             in_suspend,
    output logic             bus_reset_seen,
    output logic             session_ended
);
    typedef enum logic [6:0] {
        ST_L0      = 7'b000_0001,
        ST_IDLE    = 7'b000_0010,
        ST_LOW     = 7'b000_0100,
        ST_WAKE    = 7'b000_1000,
        ST_RESUME  = 7'b001_0000,
        ST_PING    = 7'b010_0000,
        ST_SE1     = 7'b100_0000
    } up_state_t;

    // One width serves every counter, so it must hold the longest timed phase.
    localparam int CW = $clog2(IDLE_CYCLES + WAKE_CYCLES + SE1_CYCLES + BUS_RESET_CYCLES
                               + PING_CYCLES + 2);

    initial begin
        if (IDLE_CYCLES < 1 || WAKE_CYCLES < 1) begin
            $error("native_upstream_port: counts must be at least one");
        end
    end

    up_state_t       state;
    logic [CW-1:0]   count;
    logic [CW-1:0]   reset_count;
    logic            low_is_l2;
    logic            pos;
    logic            neg;
    logic            wake_line;
    logic            resume_line;
    logic            eop_line;
    logic            ping_on_neg;

    assign pos = link.embedded_line_positive;
    assign neg = link.embedded_line_negative;
    // Resume and wake K share a line; the EOP arrives on the other one.
    assign resume_line = (speed == SPEED_LS) ? pos : neg;
    assign eop_line    = (speed == SPEED_LS) ? neg : pos;
    assign ping_on_neg = (speed != SPEED_LS);

    // Bus reset is a held positive level at FS/HS, negative at LS, outside resume, wake and SE1.
    always_ff @(posedge mclk) begin
        if (!reset_n || state == ST_RESUME || state == ST_WAKE || state == ST_SE1) begin
            reset_count <= '0;
        end else if (eop_line && !resume_line) begin
            if (reset_count != CW'(BUS_RESET_CYCLES)) begin
                reset_count <= reset_count + 1'b1;
            end
        end else begin
            reset_count <= '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state     <= ST_L0;
            count     <= '0;
            low_is_l2 <= 1'b0;
        end else if (reset_count == CW'(BUS_RESET_CYCLES)) begin
            state <= ST_L0;
            count <= '0;
        end else begin
            case (state)
                ST_L0: begin
                    count <= '0;
                    if (soft_disconnect) begin
                        state <= ST_SE1;
                    end else if (l1_request) begin
                        state     <= ST_LOW;
                        low_is_l2 <= 1'b0;
                    end else if (l2_request) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (!l2_request) begin
                        state <= ST_L0;
                    end else if (pos || neg) begin
                        count <= '0;
                    end else if (count == CW'(IDLE_CYCLES - 1)) begin
                        state     <= ST_LOW;
                        low_is_l2 <= 1'b1;
                        count     <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                ST_LOW: begin
                    count <= '0;
                    if (soft_disconnect) begin
                        state <= ST_SE1;
                    end else if (resume_line) begin
                        state <= ST_RESUME;
                    end else if (wake_request) begin
                        state <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (count == CW'(WAKE_CYCLES - 1)) begin
                        state <= ST_RESUME;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                ST_RESUME: begin
                    // The ping waits until the end of packet has left the line.
                    if (speed == SPEED_HS && pos) begin
                        state <= ST_L0;
                        count <= '0;
                    end else if (speed != SPEED_HS && eop_line) begin
                        count <= CW'(1'b1);
                    end else if (speed != SPEED_HS && count != '0) begin
                        state <= ST_PING;
                        count <= '0;
                    end
                end
                ST_PING: begin
                    if (count == CW'(PING_CYCLES - 1)) begin
                        state <= ST_L0;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                ST_SE1: begin
                    if (count == CW'(SE1_CYCLES - 1)) begin
                        state <= ST_L0;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                default: begin
                    state <= ST_L0;
                    count <= '0;
                end
            endcase
        end
    end

    // Line drivers, all registered.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            link.up_pos_out <= 1'b0;
            link.up_pos_oe  <= 1'b0;
            link.up_neg_out <= 1'b0;
            link.up_neg_oe  <= 1'b0;
        end else begin
            link.up_pos_out <= (state == ST_SE1)
                             || (state == ST_WAKE && !ping_on_neg)
                             || (state == ST_PING && !ping_on_neg);
            link.up_pos_oe  <= (state == ST_SE1)
                             || ((state == ST_WAKE || state == ST_PING) && !ping_on_neg);
            link.up_neg_out <= (state == ST_SE1)
                             || ((state == ST_WAKE || state == ST_PING) && ping_on_neg);
            link.up_neg_oe  <= (state == ST_SE1)
                             || ((state == ST_WAKE || state == ST_PING) && ping_on_neg);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            link_state     <= LINK_L0;
            in_suspend     <= 1'b0;
            bus_reset_seen <= 1'b0;
            session_ended  <= 1'b0;
        end else begin
            link_state     <= (reset_count == CW'(BUS_RESET_CYCLES)) ? LINK_RESET
                            : (state == ST_LOW) ? (low_is_l2 ? LINK_L2 : LINK_L1)
                            : LINK_L0;
            in_suspend     <= (state == ST_LOW);
            bus_reset_seen <= (reset_count == CW'(BUS_RESET_CYCLES));
            session_ended  <= (state == ST_SE1) && (count == CW'(SE1_CYCLES - 1));
        end
    end
endmodule : native_upstream_port

// ### tb/link_pm_asserts.sv
// Concurrent checks on the embedded link that joins the two port ends.
// Assumes it sees the interface signals directly, with the shared clock and reset.
`timescale 1ns/10ps
module link_pm_asserts
    import link_pm_pkg::*;
(
    input wire logic   mclk,
    input wire logic   reset_n,
    input wire speed_t speed,
    input wire logic   up_pos_out,
    input wire logic   up_pos_oe,
    input wire logic   up_neg_out,
    input wire logic   up_neg_oe,
    input wire logic   dn_pos_out,
    input wire logic   dn_pos_oe,
    input wire logic   dn_neg_out,
    input wire logic   dn_neg_oe
);
    logic        up_p;
    logic        up_n;
    logic        dn_p;
    logic        dn_n;
    logic [15:0] dn_p_run;

    assign up_p = up_pos_oe & up_pos_out;
    assign up_n = up_neg_oe & up_neg_out;
    assign dn_p = dn_pos_oe & dn_pos_out;
    assign dn_n = dn_neg_oe & dn_neg_out;

    // Counts how long the host has held the positive line, so its pulses can be sized.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dn_p_run <= 16'h0000;
        end else if (dn_p) begin
            dn_p_run <= dn_p_run + 16'h0001;
        end else begin
            dn_p_run <= 16'h0000;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    up_fs_lines_a: assert property (speed != SPEED_LS && up_p |-> up_n)
        else $error("upstream drove the positive line alone at full or high speed");
    up_ls_lines_a: assert property (speed == SPEED_LS && up_n |-> up_p)
        else $error("upstream drove the negative line alone at low speed");
    hs_no_ping_a: assert property (speed == SPEED_HS && $fell(dn_p) |=> !up_n [*8])
        else $error("upstream answered the high speed end of resume");
    hs_end_len_a: assert property (speed == SPEED_HS && $fell(dn_p) |-> dn_p_run == PING_CYCLES)
        else $error("high speed end of resume pulse has the wrong length");
    fs_ping_a: assert property (speed == SPEED_FS && $fell(dn_p) |-> ##[1:100] up_n)
        else $error("no ping on the negative line after full speed end of packet");
    ls_ping_a: assert property (speed == SPEED_LS && $fell(dn_n) |-> ##[1:100] up_p)
        else $error("no ping on the positive line after low speed end of packet");
    fs_eop_len_a: assert property (speed == SPEED_FS && $fell(dn_p) |-> dn_p_run == EOP_CYCLES)
        else $error("full speed end of packet has the wrong length");
    host_one_line_a: assert property (!(dn_p && dn_n))
        else $error("host drove both lines at once");

    cover property (speed == SPEED_FS && $fell(dn_p) ##[1:100] up_n);
    cover property (speed == SPEED_HS && $fell(dn_p));
    cover property (up_p && up_n);
endmodule : link_pm_asserts

// ### tb/tb_top.sv
// Self-checking bench for the two embedded link ends joined back to back.
// Assumes the package, the link interface and the checker are compiled first.
`timescale 1ns/10ps
module tb_top
    import link_pm_pkg::*;
;
    logic        mclk = 1'b0, reset_n = 1'b0, up_alive = 1'b1;
    speed_t      speed = SPEED_FS;
    speed_t      s;
    logic        ul1 = 1'b0, ul2 = 1'b0, uwake = 1'b0, usoft = 1'b0;
    logic        dl1 = 1'b0, dl2 = 1'b0, dres = 1'b0;
    logic        u2l2 = 1'b0, u2soft = 1'b0;
    logic [3:0]  far_lines;
    link_state_t ust, dst, st2;
    logic        usus, ubr, uend, br2, dwake, ddef;
    logic [3:0]  seen = 4'h0;
    int          n_errors = 0, total_checks = 0, ndef = 0, nend = 0;

    embedded_link_if link();
    embedded_link_if link2();

    native_upstream_port #(.IDLE_CYCLES(50), .WAKE_CYCLES(40)) u_native_upstream_port (
        .mclk(mclk), .reset_n(reset_n & up_alive), .link(link.upstream), .speed(speed),
        .l1_request(ul1), .l2_request(ul2), .wake_request(uwake), .soft_disconnect(usoft),
        .link_state(ust), .in_suspend(usus), .bus_reset_seen(ubr), .session_ended(uend));
    native_downstream_port #(.RESUME_CYCLES(20), .ACK_CYCLES(40)) u_native_downstream_port (
        .mclk(mclk), .reset_n(reset_n), .link(link.downstream), .speed(speed),
        .l1_request(dl1), .l2_request(dl2), .resume_request(dres),
        .link_state(dst), .wake_seen(dwake), .went_default(ddef));
    // Second upstream end whose host side the bench drives, to make bus reset and line noise.
    native_upstream_port #(.IDLE_CYCLES(50)) u_native_upstream_port_2 (
        .mclk(mclk), .reset_n(reset_n), .link(link2.upstream), .speed(speed),
        .l1_request(ul1), .l2_request(u2l2), .wake_request(uwake), .soft_disconnect(u2soft),
        .link_state(st2), .in_suspend(), .bus_reset_seen(br2), .session_ended());
    link_pm_asserts u_link_pm_asserts (
        .mclk(mclk), .reset_n(reset_n & up_alive), .speed(speed),
        .up_pos_out(link.up_pos_out), .up_pos_oe(link.up_pos_oe),
        .up_neg_out(link.up_neg_out), .up_neg_oe(link.up_neg_oe),
        .dn_pos_out(link.dn_pos_out), .dn_pos_oe(link.dn_pos_oe),
        .dn_neg_out(link.dn_neg_out), .dn_neg_oe(link.dn_neg_oe));

    always #4 mclk = ~mclk;

    always @(posedge mclk) begin
        seen = seen | {link.up_pos_oe & link.up_pos_out, link.up_neg_oe & link.up_neg_out,
                       link.dn_pos_oe & link.dn_pos_out, link.dn_neg_oe & link.dn_neg_out};
        ndef = ndef + int'(ddef === 1'b1);
        nend = nend + int'(uend === 1'b1);
    end

    // Lines seen as {up pos, up neg, host pos, host neg} over a resume or a wake.
    function automatic logic [3:0] exp_lines(input speed_t sp, input logic wake);
        case (sp)
            SPEED_LS: exp_lines = 4'hb;
            SPEED_FS: exp_lines = 4'h7;
            default:  exp_lines = wake ? 4'h7 : 4'h3;
        endcase
    endfunction : exp_lines

    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic do_reset(input speed_t sp);
        reset_n = 1'b0;
        up_alive = 1'b1;
        speed = sp;
        {ul1, ul2, uwake, usoft, dl1, dl2, dres, u2l2, u2soft} = 9'h000;
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
    endtask : do_reset

    // Both ends report L0 early in a resume, so the link must also have gone quiet.
    task automatic wait_l0(input int n);
        int quiet = 0;
        for (int i = 0; i < n && quiet < 8; i++) begin
            @(negedge mclk);
            if (ust === LINK_L0 && dst === LINK_L0 && link.embedded_line_positive === 1'b0
                && link.embedded_line_negative === 1'b0) begin
                quiet++;
            end else begin
                quiet = 0;
            end
        end
    endtask : wait_l0

    task automatic hold_link2(input int n);
        link2.dn_pos_oe = (s != SPEED_LS);
        link2.dn_neg_oe = (s == SPEED_LS);
        repeat (n) @(negedge mclk);
        {link2.dn_pos_oe, link2.dn_neg_oe} = 2'b00;
    endtask : hold_link2

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // The run needs some 9,000 cycles; the limit leaves generous slack.
    initial begin
        #(40_000 * 8);
        n_errors++;
        end_sim();
    end

    initial begin
        {link2.dn_pos_out, link2.dn_neg_out, link2.dn_pos_oe, link2.dn_neg_oe} = 4'hc;
        void'($urandom(32'hb859_ffec));
        for (int r = 0; r < 4; r++) begin
            s = (r < 3) ? speed_t'(2'(r)) : speed_t'(2'($urandom_range(2, 0)));
            do_reset(s);
            {dl2, ul2, u2l2} = 3'b111;
            repeat (30) @(negedge mclk);
            check("suspend_early", 4'h0, {3'h0, usus});
            hold_link2(1);
            repeat (30 + $urandom_range(5, 0)) @(negedge mclk);
            check("up_l2", 4'(LINK_L2), 4'(ust));
            check("dn_l2", 4'(LINK_L2), 4'(dst));
            check("noisy_idle", 4'h1, {3'h0, st2 !== LINK_L2});
            {seen, ndef} = '0;
            {ul2, dl2, dres} = 3'b001;
            wait_l0(3000);
            dres = 1'b0;
            check("resume_up", 4'(LINK_L0), 4'(ust));
            check("resume_dn", 4'(LINK_L0), 4'(dst));
            check("resume_lines", exp_lines(s, 1'b0), seen);
            check("resume_default", 4'h0, 4'(ndef));
            check("late_l2", 4'(LINK_L2), 4'(st2));
            hold_link2(BUS_RESET_CYCLES - 32);
            check("reset_early", 4'h0, {3'h0, br2});
            @(negedge mclk);
            hold_link2(BUS_RESET_CYCLES + $urandom_range(60, 10));
            check("bus_reset", 4'(LINK_RESET), 4'(st2));
            {u2l2, u2soft} = 2'b01;
            repeat (4) @(negedge mclk);
            far_lines = {2'h0, link2.embedded_line_positive, link2.embedded_line_negative};
            check("far_se1", 4'h3, far_lines);
            u2soft = 1'b0;
            $display("test suspend_resume done");
            seen = 4'h0;
            {ul1, dl1} = 2'b11;
            repeat (5) @(negedge mclk);
            check("up_l1", 4'(LINK_L1), 4'(ust));
            check("up_susp", 4'h1, {3'h0, usus});
            check("dn_l1", 4'(LINK_L1), 4'(dst));
            uwake = 1'b1;
            @(negedge mclk);
            ul1 = 1'b0;
            for (int i = 0; i < 500 && dwake !== 1'b1; i++) begin
                @(negedge mclk);
            end
            check("wake_seen", 4'h1, {3'h0, dwake});
            dl1 = 1'b0;
            wait_l0(3000);
            uwake = 1'b0;
            check("wake_up", 4'(LINK_L0), 4'(ust));
            check("wake_dn", 4'(LINK_L0), 4'(dst));
            check("wake_lines", exp_lines(s, 1'b1), seen);
            $display("test remote_wake done");
            {seen, nend} = '0;
            usoft = 1'b1;
            repeat (2) @(negedge mclk);
            usoft = 1'b0;
            for (int i = 0; i < 1000 && nend == 0; i++) begin
                @(negedge mclk);
            end
            repeat (5) @(negedge mclk);
            check("session_end", 4'h1, 4'(nend));
            check("se1_lines", 4'hc, seen & 4'hc);
            $display("test soft_disconnect done");
            if (s != SPEED_HS) begin
                do_reset(s);
                up_alive = 1'b0;
                dl2 = 1'b1;
                repeat (5) @(negedge mclk);
                ndef = 0;
                {dl2, dres} = 2'b01;
                for (int i = 0; i < 3000 && ndef == 0; i++) begin
                    @(negedge mclk);
                end
                dres = 1'b0;
                check("no_ping_default", 4'h1, 4'(ndef));
                $display("test missing_ping done");
            end
        end
        end_sim();
    end
endmodule : tb_top
